// ---- verilog/acr_pkg.sv ----
// constants shared by the converter control and result register block
package acr_pkg;
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned RES_W       = 10;
	localparam int unsigned CHS_W       = 5;
	localparam int unsigned CS_W        = 3;
	localparam int unsigned DIV_W       = 6;
	// register byte offsets
	localparam logic [3:0] OFF_CTRL0    = 4'h0;
	localparam logic [3:0] OFF_CLKSEL   = 4'h4;
	localparam logic [3:0] OFF_RESH     = 4'h8;
	localparam logic [3:0] OFF_RESL     = 4'hC;
	// field positions
	localparam int unsigned EN_BIT      = 0;
	localparam int unsigned GO_BIT      = 1;
	localparam int unsigned CHS_LSB     = 2;
	localparam int unsigned CS_LSB      = 4;
	localparam int unsigned RESH_W      = 2;
	// reset values
	localparam logic [7:0] CTRL0_RST    = 8'h00;
	localparam logic [7:0] CLKSEL_RST   = 8'h00;
	// conversion clock select codes
	localparam logic [CS_W-1:0] CS_DIV8  = 3'h1;
	localparam logic [CS_W-1:0] CS_DIV16 = 3'h5;
	localparam logic [CS_W-1:0] CS_DIV32 = 3'h2;
	localparam logic [CS_W-1:0] CS_DIV64 = 3'h6;
	localparam logic [CS_W-1:0] CS_OSC   = 3'h3;
	// divider terminal counts (divisor minus one)
	localparam logic [DIV_W-1:0] TC_DIV8  = 6'h07;
	localparam logic [DIV_W-1:0] TC_DIV16 = 6'h0F;
	localparam logic [DIV_W-1:0] TC_DIV32 = 6'h1F;
	localparam logic [DIV_W-1:0] TC_DIV64 = 6'h3F;
	localparam logic [3:0]       TC_OSC   = 4'hF;
	localparam logic [RES_W-1:0] MSB_TRIAL = 10'h200;
	localparam logic [3:0]       MSB_IDX   = 4'h9;
	typedef enum logic [0:0] {ACR_IDLE, ACR_CONV} acr_state_t;
endpackage : acr_pkg

// ---- verilog/acr_top.sv ----
// converter control, conversion clock and result registers behind an apb slave
// Behaviour
// - result high bits 1:0 hold result MSBs
// - result high bits 7:2 read zero
// - result low register holds eight LSBs
// - result is a 10-bit unsigned code
// - hold capacitor never discharged after conversion
// - start bit stays set until conversion completes, enable is cleared or sleep is requested
// - enable bit zero powers converter down
// - five-bit channel field routes analog source
// - no conversion during sleep
`timescale 1ns/100ps
module acr_top #(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [ADDR_W-1:0]             paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          sleep_req,
	input  wire logic                          osc_pin,
	input  wire logic                          comp_pin,
	output logic                               adc_power,
	output logic      [acr_pkg::CHS_W-1:0]     chan_sel,
	output logic                               sample_en,
	output logic      [acr_pkg::RES_W-1:0]     dac_code
);
	if (ADDR_W < 5)
		$error("ADDR_W must be at least 5");

	// decode: bit 2 valid, bits 1:0 register index
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		if (a[ADDR_W-1:4] != '0)
			return 3'h0;
		unique case (a[3:0])
			acr_pkg::OFF_CTRL0:  return 3'h4;
			acr_pkg::OFF_CLKSEL: return 3'h5;
			acr_pkg::OFF_RESH:   return 3'h6;
			acr_pkg::OFF_RESL:   return 3'h7;
			default:             return 3'h0;
		endcase
	endfunction : reg_sel

	// pin synchronisers: bit 0 comparator, bit 1 oscillator
	logic [1:0] s1_q, s2_q, s3_q, st_q, st_d;
	always_comb
	begin
		st_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & st_q);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			st_q <= 2'h0;
		end
		else
		begin
			s1_q <= {osc_pin, comp_pin};
			s2_q <= s1_q;
			s3_q <= s2_q;
			st_q <= st_d;
		end
	end
	logic osc_rise;
	assign osc_rise = st_d[1] & ~st_q[1];

	// apb registers and conversion engine
	acr_pkg::acr_state_t             state_q, state_d;
	logic                            en_q, en_d, go_q, go_d;
	logic [acr_pkg::CHS_W-1:0]       chs_q, chs_d;
	logic [acr_pkg::CS_W-1:0]        cs_q, cs_d;
	logic [acr_pkg::RES_W-1:0]       res_q, res_d, trial_q, trial_d;
	logic [3:0]                      idx_q, idx_d, osc_cnt_q, osc_cnt_d;
	logic [acr_pkg::DIV_W-1:0]       div_cnt_q, div_cnt_d, tc;
	logic                            tick_q, tick_d, samp_q, samp_d;
	logic                            rdy_q, rdy_d, err_q, err_d;
	logic [31:0]                     rd_q, rd_d;
	logic [2:0]                      sel;
	logic                            access, run;
	logic [acr_pkg::RES_W-1:0]       keep;

	always_comb
	begin
		sel     = reg_sel(paddr);
		access  = psel & penable & rdy_q;
		rdy_d   = psel & penable & ~rdy_q;
		err_d   = rdy_d & ~sel[2];
		rd_d    = 32'h0000_0000;
		en_d    = en_q;
		chs_d   = chs_q;
		cs_d    = cs_q;
		go_d    = go_q;
		state_d = state_q;
		trial_d = trial_q;
		idx_d   = idx_q;
		res_d   = res_q;
		if (rdy_d && !pwrite && sel[2])
		begin
			unique case (sel[1:0])
				2'h0: rd_d[7:0] = {1'b0, chs_q, go_q, en_q};
				2'h1: rd_d[7:0] = {1'b0, cs_q, 4'h0};
				2'h2: rd_d[7:0] = {6'h00, res_q[acr_pkg::RES_W-1:8]};
				2'h3: rd_d[7:0] = res_q[7:0];
			endcase
		end
		if (access && pwrite && sel == 3'h4)
		begin
			en_d  = pwdata[acr_pkg::EN_BIT];
			chs_d = pwdata[acr_pkg::CHS_LSB +: acr_pkg::CHS_W];
			if (pwdata[acr_pkg::GO_BIT] && pwdata[acr_pkg::EN_BIT] && !sleep_req
				&& state_q == acr_pkg::ACR_IDLE)
			begin
				go_d    = 1'b1;
				state_d = acr_pkg::ACR_CONV;
				trial_d = acr_pkg::MSB_TRIAL;
				idx_d   = acr_pkg::MSB_IDX;
			end
		end
		if (access && pwrite && sel == 3'h5)
			cs_d = pwdata[acr_pkg::CS_LSB +: acr_pkg::CS_W];
		// successive approximation, one trial bit per conversion clock
		keep = trial_q;
		if (!st_q[0])
			keep[idx_q] = 1'b0;
		if (state_q == acr_pkg::ACR_CONV && tick_q)
		begin
			if (idx_q == 4'h0)
			begin
				res_d   = keep;
				go_d    = 1'b0;
				state_d = acr_pkg::ACR_IDLE;
			end
			else
			begin
				trial_d = keep;
				trial_d[idx_q - 4'h1] = 1'b1;
				idx_d   = idx_q - 4'h1;
			end
		end
		if (!en_d || sleep_req)
		begin
			go_d    = 1'b0;
			state_d = acr_pkg::ACR_IDLE;
		end
	end

	// conversion clock enable
	always_comb
	begin
		run       = state_q == acr_pkg::ACR_CONV;
		div_cnt_d = '0;
		osc_cnt_d = osc_cnt_q;
		tick_d    = 1'b0;
		unique case (cs_q)
			acr_pkg::CS_DIV8:  tc = acr_pkg::TC_DIV8;
			acr_pkg::CS_DIV16: tc = acr_pkg::TC_DIV16;
			acr_pkg::CS_DIV32: tc = acr_pkg::TC_DIV32;
			acr_pkg::CS_DIV64: tc = acr_pkg::TC_DIV64;
			default:           tc = '0;
		endcase
		if (!run)
			osc_cnt_d = 4'h0;
		else if (cs_q == acr_pkg::CS_OSC)
		begin
			if (osc_rise)
			begin
				osc_cnt_d = osc_cnt_q + 4'h1;
				tick_d    = osc_cnt_q == acr_pkg::TC_OSC;
			end
		end
		else if (tc != '0)
		begin
			div_cnt_d = (div_cnt_q == tc) ? '0 : div_cnt_q + 6'h01;
			tick_d    = div_cnt_q == tc;
		end
		// sampling switch closed while enabled, idle and out of sleep; hold is left charged
		samp_d = en_d && !sleep_req && state_d == acr_pkg::ACR_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q   <= acr_pkg::ACR_IDLE;
			en_q      <= acr_pkg::CTRL0_RST[acr_pkg::EN_BIT];
			go_q      <= acr_pkg::CTRL0_RST[acr_pkg::GO_BIT];
			chs_q     <= acr_pkg::CTRL0_RST[acr_pkg::CHS_LSB +: acr_pkg::CHS_W];
			cs_q      <= acr_pkg::CLKSEL_RST[acr_pkg::CS_LSB +: acr_pkg::CS_W];
			res_q     <= '0;
			trial_q   <= '0;
			idx_q     <= 4'h0;
			div_cnt_q <= '0;
			osc_cnt_q <= 4'h0;
			tick_q    <= 1'b0;
			samp_q    <= 1'b0;
			rdy_q     <= 1'b0;
			err_q     <= 1'b0;
			rd_q      <= 32'h0000_0000;
		end
		else
		begin
			state_q   <= state_d;
			en_q      <= en_d;
			go_q      <= go_d;
			chs_q     <= chs_d;
			cs_q      <= cs_d;
			res_q     <= res_d;
			trial_q   <= trial_d;
			idx_q     <= idx_d;
			div_cnt_q <= div_cnt_d;
			osc_cnt_q <= osc_cnt_d;
			tick_q    <= tick_d;
			samp_q    <= samp_d;
			rdy_q     <= rdy_d;
			err_q     <= err_d;
			rd_q      <= rd_d;
		end
	end

	assign prdata    = rd_q;
	assign pready    = rdy_q;
	assign pslverr   = err_q;
	assign adc_power = en_q;
	assign chan_sel  = chs_q;
	assign sample_en = samp_q;
	assign dac_code  = trial_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	div_eight_a: assert property (tick_q && run && cs_q == acr_pkg::CS_DIV8
		&& $stable(cs_q) |=> !tick_q [*7]) else $error("divide by 8 tick spacing wrong");
	resh_msb_a: assert property (rdy_d && !pwrite && sel == 3'h6
		|=> prdata[1:0] == $past(res_q[9:8])) else $error("result high bits wrong");
	resh_zero_a: assert property (rdy_d && !pwrite && sel == 3'h6
		|=> prdata[7:2] == 6'h00) else $error("result high upper bits not zero");
	resl_bits_a: assert property (rdy_d && !pwrite && sel == 3'h7
		|=> prdata[7:0] == $past(res_q[7:0])) else $error("result low bits wrong");
	sar_done_a: assert property (run && tick_q && idx_q == 4'h0 && en_d && !sleep_req
		|=> !go_q && res_q[0] == $past(st_q[0])) else $error("last trial not stored");
	hold_kept_a: assert property (!go_q && en_q && !sleep_req && !$past(sleep_req)
		&& !$past(go_q) |-> sample_en) else $error("sampling switch open while idle");
	osc_tick_a: assert property (tick_q && cs_q == acr_pkg::CS_OSC
		|-> $past(osc_rise)) else $error("oscillator tick without oscillator edge");
	go_busy_a: assert property (go_q == (state_q == acr_pkg::ACR_CONV)
		) else $error("start bit disagrees with conversion state");
	go_rise_a: assert property ($rose(go_q)
		|-> $past(access && pwrite && sel == 3'h4 && pwdata[acr_pkg::GO_BIT]))
		else $error("start bit set without a start write");
	go_fall_a: assert property ($fell(go_q)
		|-> $past(tick_q && idx_q == 4'h0) || !$past(en_d) || $past(sleep_req))
		else $error("start bit cleared before conversion end");
	power_off_a: assert property (!en_q |-> !go_q) else $error("conversion while disabled");
	chan_write_a: assert property (access && pwrite && sel == 3'h4
		|=> chan_sel == $past(pwdata[6:2])) else $error("channel select not written");
	sleep_stop_a: assert property (sleep_req |=> !go_q && !sample_en
		) else $error("converter active in sleep");
endmodule : acr_top

// ---- sim/acr_analog_model.sv ----
// analog input, sampling capacitor and conversion oscillator model
`timescale 1ns/100ps
module acr_analog_model (
	input  wire logic       sample_en,
	input  wire logic [9:0] level,
	input  wire logic [9:0] dac_code,
	output logic            comp_pin,
	output logic            osc_pin
);
	logic [9:0] held;
	initial osc_pin = 1'b0;
	always #400 osc_pin = ~osc_pin;
	// capacitor keeps the last sample while the switch is open
	always @*
	begin
		if (sample_en)
			held = level;
	end
	// input sits half a step above level, so a trial equal to it is kept
	assign comp_pin = (held >= dac_code);
endmodule : acr_analog_model

// ---- sim/tb_top.sv ----
// testbench for the converter control and result registers
`timescale 1ns/100ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, sleep_req, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, osc_pin, comp_pin, adc_power, sample_en;
	logic [4:0]  chan_sel;
	logic [9:0]  dac_code, level;
	int          fails, checks, cyc, t0, el, i;
	logic [2:0]  cs [5] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
	int          dv [5] = '{8, 16, 32, 64, 128};
	logic [9:0]  lv [5] = '{10'h3FF, 10'h000, 10'h155, 10'h2AA, 10'h201};
	logic [2:0]  rs [3] = '{3'h0, 3'h4, 3'h7};
	acr_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sleep_req, .osc_pin, .comp_pin, .adc_power, .chan_sel,
		.sample_en, .dac_code);
	acr_analog_model model (.sample_en, .level, .dac_code, .comp_pin, .osc_pin);
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
			fails++;
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			fails++;
			test_done;
		end
	endtask : apb
	initial
	begin
		{presetn, psel, penable, pwrite, sleep_req} = '0;
		paddr = '0;
		pwdata = '0;
		level = '0;
		cyc = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			apb(1'b0, 12'(4 * i), 32'h0);
			check("reset_val", rd, 32'h0);
		end
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped_err", {31'h0, err}, 32'h1);
		apb(1'b1, 12'h008, 32'hFF);
		apb(1'b0, 12'h008, 32'h0);
		check("result_high_ro", rd, 32'h0);
		apb(1'b1, 12'h000, 32'h15);
		apb(1'b0, 12'h000, 32'h0);
		check("ctrl0", rd, 32'h15);
		check("chan_sel", {27'h0, chan_sel}, 32'h5);
		check("power_on", {31'h0, adc_power}, 32'h1);
		for (i = 0; i < 5; i++)
		begin
			level <= lv[i];
			apb(1'b1, 12'h004, {25'h0, cs[i], 4'h0});
			repeat (50) @(posedge pclk);
			apb(1'b1, 12'h000, 32'h17);
			t0 = cyc;
			@(posedge pclk);
			check("first_trial", {22'h0, dac_code}, 32'h200);
			do
				apb(1'b0, 12'h000, 32'h0);
			while (rd[1] === 1'b1 && cyc - t0 < 3000);
			el = cyc - t0;
			if (rd[1] !== 1'b0)
			begin
				fails++;
				test_done;
			end
			check("go_done", rd, 32'h15);
			check("conv_time", 32'(el + 8 >= 10 * dv[i] && el <= 10 * dv[i] + 40), 32'h1);
			apb(1'b0, 12'h008, 32'h0);
			check("result_high", rd, {30'h0, lv[i][9:8]});
			apb(1'b0, 12'h00C, 32'h0);
			check("result_low", rd, {24'h0, lv[i][7:0]});
			check("sampling", {31'h0, sample_en}, 32'h1);
		end
		for (i = 0; i < 3; i++)
		begin
			apb(1'b1, 12'h004, {25'h0, rs[i], 4'h0});
			apb(1'b1, 12'h000, 32'h17);
			repeat (200) @(posedge pclk);
			apb(1'b0, 12'h000, 32'h0);
			check("reserved_busy", rd, 32'h17);
			apb(1'b1, 12'h000, 32'h14);
			apb(1'b0, 12'h000, 32'h0);
			check("abort", rd, 32'h14);
			check("power_off", {31'h0, adc_power}, 32'h0);
			apb(1'b0, 12'h00C, 32'h0);
			check("result_kept", rd, 32'h01);
			apb(1'b1, 12'h000, 32'h15);
		end
		apb(1'b1, 12'h004, 32'h10);
		sleep_req <= 1'b1;
		apb(1'b1, 12'h000, 32'h17);
		apb(1'b0, 12'h000, 32'h0);
		check("sleep_start", rd, 32'h15);
		check("sleep_hold", {31'h0, sample_en}, 32'h0);
		sleep_req <= 1'b0;
		test_done;
	end
endmodule : tb_top
